// ==== wrc_defines.vh ====
// Constants for the wake rate configuration register block.
`ifndef WRC_DEFINES_VH
`define WRC_DEFINES_VH
`define WRC_IDX_RATE 8'h11
`define WRC_IDX_INDIRECT 8'h29
`define WRC_IDX_POWER 8'h1C
`define WRC_IDX_MODE 8'h10
`define WRC_ADDR_RATE 10'h044
`define WRC_ADDR_INDIRECT 10'h0A4
`define WRC_ADDR_POWER 10'h070
`define WRC_ADDR_MODE 10'h040
`define WRC_ADDR_STATUS 10'h100
`define WRC_RATE_RESET 8'h00
`define WRC_POWER_RESET 8'h00
`define WRC_MODE_RESET 8'h00
`define WRC_INDIRECT_RESET 8'h00
`define WRC_CODE_MSB 3
`define WRC_CODE_LSB 0
`define WRC_SEL_MSB 6
`define WRC_SEL_LSB 4
`define WRC_WPWR_MSB 2
`define WRC_WPWR_LSB 0
`define WRC_SPWR_MSB 6
`define WRC_SPWR_LSB 4
`define WRC_MODE_CONTINUOUS_WAKE_MODE 3'h5
`define WRC_PWR_LOW 3'h0
`define WRC_PWR_ULTRA 3'h3
`define WRC_PWR_PREC 3'h4
`define WRC_SEL_OFF 3'h0
`define WRC_SEL_TRIM 3'h1
`define WRC_SEL_WPICK 3'h2
`define WRC_SEL_SPICK 3'h3
`define WRC_SEL_WCNTL 3'h4
`define WRC_SEL_WCNTH 3'h5
`define WRC_SEL_SCNTL 3'h6
`define WRC_SEL_SCNTH 3'h7
`endif

// ==== wrc_rate_decode.v ====
// Decodes the wake rate code and power mode into a nominal rate in Hz.
`timescale 1ns/1ps
`include "wrc_defines.vh"
module wrc_rate_decode (
	// Selection inputs.
	input wire [3:0] rateCode,
	input wire [2:0] powerMode,
	// Decoded rate.
	output reg [10:0] rateHz,
	output reg rateValid
);
	always @* begin
		rateHz = 11'h000;
		rateValid = 1'b1;
		// A rate of zero marks an unsupported combination.
		case (powerMode)
			`WRC_PWR_ULTRA: begin
				case (rateCode)
					4'h6: rateHz = 11'h019;
					4'h7: rateHz = 11'h032;
					4'h8: rateHz = 11'h064;
					4'h9: rateHz = 11'h0BE;
					4'hA: rateHz = 11'h17C;
					4'hB: rateHz = 11'h2EE;
					4'hC: rateHz = 11'h44C;
					4'hF: rateHz = 11'h514;
					default: rateHz = 11'h000;
				endcase
			end
			`WRC_PWR_PREC: begin
				case (rateCode)
					4'h5: rateHz = 11'h00E;
					4'h6: rateHz = 11'h01C;
					4'h7: rateHz = 11'h037;
					4'h8: rateHz = 11'h050;
					4'hF: rateHz = 11'h064;
					default: rateHz = 11'h000;
				endcase
			end
			default: begin
				case (rateCode)
					4'h5: rateHz = 11'h00E;
					4'h6: rateHz = 11'h01C;
					4'h7: rateHz = 11'h036;
					4'h8: rateHz = 11'h069;
					4'h9: rateHz = 11'h0D2;
					4'hA: rateHz = 11'h190;
					4'hB: rateHz = 11'h258;
					4'hF: rateHz = 11'h2EE;
					default: rateHz = 11'h000;
				endcase
			end
		endcase
		if (rateHz == 11'h000) begin
			rateValid = 1'b0;
		end
	end
endmodule

// ==== wrc_wake_rate_config.v ====
// Wake rate configuration register bank with an AXI4-Lite slave.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "wrc_defines.vh"
module wrc_wake_rate_config (
	// Clock and reset.
	input wire core_clk,
	input wire srst,
	// AXI4-Lite write address and data.
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response.
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read.
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Rate outputs to the sampling logic.
	output reg [3:0] wakeRateCode,
	output reg [10:0] wakeRateHz,
	output reg wakeSampleEnable,
	output reg [3:0] wakeCurrentTrim,
	output reg [3:0] sniffCurrentTrim,
	output reg [4:0] wakeFrequencyPick,
	output reg [4:0] sniffFrequencyPick,
	output reg [15:0] wakeClockCount,
	output reg [15:0] sniffClockCount,
	output reg [2:0] sniffPowerMode
);
	reg [7:0] wakeRateConfig;
	reg [7:0] powerConfig;
	reg [7:0] modeControl;
	reg [7:0] indirectPlain;
	reg [9:0] wrAddr;
	reg wrAddrHeld;
	reg [7:0] wrData;
	reg wrDataHeld;
	reg wrLaneOk;
	wire [2:0] manualRateSelect;
	wire [2:0] wakePowerMode;
	wire [10:0] decodedHz;
	wire decodedValid;
	wire continuousWakeMode;
	reg [7:0] indirectView;
	reg [31:0] next_rdata;
	reg [1:0] next_rresp;
	wire doWrite;

	assign manualRateSelect = wakeRateConfig[`WRC_SEL_MSB:`WRC_SEL_LSB];
	assign wakePowerMode = powerConfig[`WRC_WPWR_MSB:`WRC_WPWR_LSB];
	assign continuousWakeMode = modeControl[2:0] == `WRC_MODE_CONTINUOUS_WAKE_MODE;
	assign doWrite = wrAddrHeld && wrDataHeld && !s_axi_bvalid;

	////////////////////////////////////////////////////////////////////////
	wrc_rate_decode rateDecode (
		.rateCode(wakeRateConfig[`WRC_CODE_MSB:`WRC_CODE_LSB]),
		.powerMode(wakePowerMode),
		.rateHz(decodedHz),
		.rateValid(decodedValid)
	);

	////////////////////////////////////////////////////////////////////////
	// The indirect register shows the shadow that the select field names.
	always @* begin
		case (manualRateSelect)
			`WRC_SEL_OFF: indirectView = indirectPlain;
			`WRC_SEL_TRIM: indirectView = {sniffCurrentTrim, wakeCurrentTrim};
			`WRC_SEL_WPICK: indirectView = {3'h0, wakeFrequencyPick};
			`WRC_SEL_SPICK: indirectView = {3'h0, sniffFrequencyPick};
			`WRC_SEL_WCNTL: indirectView = wakeClockCount[7:0];
			`WRC_SEL_WCNTH: indirectView = wakeClockCount[15:8];
			`WRC_SEL_SCNTL: indirectView = sniffClockCount[7:0];
			default: indirectView = sniffClockCount[15:8];
		endcase
	end

	always @* begin
		next_rdata = 32'h00000000;
		next_rresp = 2'h0;
		if (s_axi_araddr[11:2] == `WRC_ADDR_RATE >> 2) begin
			next_rdata = {24'h000000, wakeRateConfig};
		end else if (s_axi_araddr[11:2] == `WRC_ADDR_INDIRECT >> 2) begin
			next_rdata = {24'h000000, indirectView};
		end else if (s_axi_araddr[11:2] == `WRC_ADDR_POWER >> 2) begin
			next_rdata = {24'h000000, powerConfig};
		end else if (s_axi_araddr[11:2] == `WRC_ADDR_MODE >> 2) begin
			next_rdata = {24'h000000, modeControl};
		end else if (s_axi_araddr[11:2] == `WRC_ADDR_STATUS >> 2) begin
			next_rdata = {19'h00000, wakeSampleEnable, decodedValid,
				decodedHz};
		end else begin
			next_rresp = 2'h2;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write channel: address and data are captured in either order.
	always @(posedge core_clk) begin
		if (srst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			wrAddrHeld <= 1'b0;
			wrDataHeld <= 1'b0;
			wrAddr <= 10'h000;
			wrData <= 8'h00;
			wrLaneOk <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				wrAddr <= s_axi_awaddr[11:2];
				wrAddrHeld <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wrData <= s_axi_wdata[7:0];
				wrLaneOk <= s_axi_wstrb[0];
				wrDataHeld <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
				if (wrAddr != `WRC_ADDR_RATE >> 2 &&
					wrAddr != `WRC_ADDR_INDIRECT >> 2 &&
					wrAddr != `WRC_ADDR_POWER >> 2 &&
					wrAddr != `WRC_ADDR_MODE >> 2 &&
					wrAddr != `WRC_ADDR_STATUS >> 2) begin
					s_axi_bresp <= 2'h2;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				wrAddrHeld <= 1'b0;
				wrDataHeld <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Register and shadow updates; host keeps codes legal, bit seven zero.
	always @(posedge core_clk) begin
		if (srst) begin
			wakeRateConfig <= `WRC_RATE_RESET;
			powerConfig <= `WRC_POWER_RESET;
			modeControl <= `WRC_MODE_RESET;
			indirectPlain <= `WRC_INDIRECT_RESET;
			wakeCurrentTrim <= 4'h0;
			sniffCurrentTrim <= 4'h0;
			wakeFrequencyPick <= 5'h00;
			sniffFrequencyPick <= 5'h00;
			wakeClockCount <= 16'h0000;
			sniffClockCount <= 16'h0000;
		end else if (doWrite && wrLaneOk) begin
			if (wrAddr == `WRC_ADDR_RATE >> 2) begin
				wakeRateConfig <= wrData;
			end else if (wrAddr == `WRC_ADDR_POWER >> 2) begin
				powerConfig <= wrData;
			end else if (wrAddr == `WRC_ADDR_MODE >> 2) begin
				modeControl <= wrData;
			end else if (wrAddr == `WRC_ADDR_INDIRECT >> 2) begin
				case (manualRateSelect)
					`WRC_SEL_OFF: indirectPlain <= wrData;
					`WRC_SEL_TRIM: begin
						sniffCurrentTrim <= wrData[7:4];
						wakeCurrentTrim <= wrData[3:0];
					end
					`WRC_SEL_WPICK: wakeFrequencyPick <= wrData[4:0];
					`WRC_SEL_SPICK: sniffFrequencyPick <= wrData[4:0];
					`WRC_SEL_WCNTL: wakeClockCount[7:0] <= wrData;
					`WRC_SEL_WCNTH: wakeClockCount[15:8] <= wrData;
					`WRC_SEL_SCNTL: sniffClockCount[7:0] <= wrData;
					default: sniffClockCount[15:8] <= wrData;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read channel: one cycle from address to data.
	always @(posedge core_clk) begin
		if (srst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered rate outputs.
	always @(posedge core_clk) begin
		if (srst) begin
			wakeRateCode <= 4'h0;
			wakeRateHz <= 11'h000;
			wakeSampleEnable <= 1'b0;
			sniffPowerMode <= 3'h0;
		end else begin
			wakeRateCode <= wakeRateConfig[`WRC_CODE_MSB:`WRC_CODE_LSB];
			wakeRateHz <= decodedHz;
			wakeSampleEnable <= continuousWakeMode && decodedValid;
			sniffPowerMode <= powerConfig[`WRC_SPWR_MSB:`WRC_SPWR_LSB];
		end
	end
endmodule

// ==== wrc_monitor.sv ====
// Port checks for the wake rate configuration block.
`timescale 1ns/1ps
module wrc_monitor (
	// Clock and reset.
	input wire core_clk,
	input wire srst,
	// Bus handshakes.
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [1:0] s_axi_bresp,
	input wire [1:0] s_axi_rresp,
	input wire [31:0] s_axi_rdata,
	// Rate outputs.
	input wire wakeSampleEnable,
	input wire [3:0] wakeRateCode,
	input wire [10:0] wakeRateHz,
	input wire [15:0] wakeClockCount,
	input wire [15:0] sniffClockCount,
	input wire [2:0] sniffPowerMode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rdata");
	a_read_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("rdata dropped");
	a_write_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("bresp dropped");
	a_write_busy: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("aw open");
	a_read_busy: assert property (
		s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
	a_code_write: assert property (
		$changed(wakeRateCode) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("code moved");
	a_rate_legal: assert property (
		wakeRateHz != 0 && $stable(wakeRateCode)
		|-> wakeRateCode inside {[5:12], 15}) else $error("bad rate");
	a_enable_rate: assert property (
		wakeSampleEnable && $stable(wakeRateHz) |-> wakeRateHz != 0)
		else $error("enable without rate");
	a_count_write: assert property (
		$changed({wakeClockCount, sniffClockCount})
		|-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("count moved");
	a_sniff_power: assert property (
		$changed(sniffPowerMode) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("sniff mode moved");
	cover property (wakeSampleEnable);
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	cover property ($changed(wakeClockCount));
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

// ==== tb.sv ====
// Self-checking bench for the wake rate configuration block.
`timescale 1ns/1ps
`include "wrc_defines.vh"
module tb;
	logic core_clk = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, rd;
	logic [3:0] s_axi_wstrb = 0;
	logic [1:0] rr, br;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, wakeSampleEnable;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [3:0] wakeRateCode, wakeCurrentTrim, sniffCurrentTrim;
	wire [10:0] wakeRateHz;
	wire [4:0] wakeFrequencyPick, sniffFrequencyPick;
	wire [15:0] wakeClockCount, sniffClockCount;
	wire [2:0] sniffPowerMode;
	int miscompares = 0, tests_run = 0, cyc = 0;
	logic [2:0] pm[3] = '{3'h0, 3'h3, 3'h4};
	int hzT[3][16] = '{'{0,0,0,0,0,14,28,54,105,210,400,600,0,0,0,750},
		'{0,0,0,0,0,0,25,50,100,190,380,750,1100,0,0,1300},
		'{0,0,0,0,0,14,28,55,80,0,0,0,0,0,0,100}};
	wrc_wake_rate_config dut (.*);
	always #5 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////////////////
	function automatic int hz(logic [3:0] c, logic [2:0] p);
		return hzT[p == 3 ? 1 : p == 4 ? 2 : 0][c];
	endfunction
	function automatic logic [7:0] sh(logic [2:0] s);
		case (s)
			1: return {sniffCurrentTrim, wakeCurrentTrim};
			2: return {3'h0, wakeFrequencyPick};
			3: return {3'h0, sniffFrequencyPick};
			4: return wakeClockCount[7:0];
			5: return wakeClockCount[15:8];
			6: return sniffClockCount[7:0];
			default: return sniffClockCount[15:8];
		endcase
	endfunction
	task automatic chk(input string n, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d,
		input logic [3:0] s);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		do begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1;
		end while (!(s_axi_bvalid && s_axi_bready));
		br = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task automatic rd_(input logic [11:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do begin
			@(posedge core_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1;
		end while (!(s_axi_rvalid && s_axi_rready));
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task automatic give_verdict;
		if (miscompares == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 6000) begin
			miscompares++;
			give_verdict();
		end
	end
	initial begin
		logic [7:0] v, c;
		int e;
		v = $urandom(53);
		repeat (12) @(posedge core_clk);
		srst <= 0;
		rd_(`WRC_ADDR_RATE);
		chk("rate reset", rd, `WRC_RATE_RESET);
		for (int s = 0; s < 8; s++) begin
			v = $urandom;
			wr(`WRC_ADDR_RATE, {1'b0, s[2:0], 4'h6}, 4'hF);
			wr(`WRC_ADDR_INDIRECT, v, 4'hF);
			rd_(`WRC_ADDR_INDIRECT);
			c = (s == 2 || s == 3) ? v & 8'h1F : v;
			chk("indirect", rd, {24'h0, c});
			if (s == 0) chk("plain", {wakeClockCount, sniffClockCount}, 0);
			else chk("shadow", sh(s[2:0]), c);
		end
		wr(`WRC_ADDR_INDIRECT, ~c, 4'h0);
		chk("no strobe", sh(3'h7), c);
		chk("no strobe resp", br, 2'h0);
		foreach (pm[j]) for (int k = 0; k < 16; k++) begin
			if (hz(k[3:0], pm[j]) == 0) continue;
			v = $urandom;
			wr(`WRC_ADDR_POWER, {1'b0, v[2:0], 1'b0, pm[j]}, 4'hF);
			wr(`WRC_ADDR_RATE, {4'h0, k[3:0]}, 4'hF);
			wr(`WRC_ADDR_MODE, {5'h0, k[0] ? 3'h5 : v[5:3]}, 4'hF);
			rd_(`WRC_ADDR_STATUS);
			e = hz(k[3:0], pm[j]);
			chk("code", wakeRateCode, k);
			chk("hz", wakeRateHz, e);
			chk("status", rd[10:0], e);
			chk("sniff mode", sniffPowerMode, v[2:0]);
			chk("enable", wakeSampleEnable,
				(k[0] || v[5:3] == 5) && e != 0);
		end
		rd_(12'h3FC);
		chk("unmapped resp", rr, 2'h2);
		chk("unmapped data", rd, 0);
		wr(12'h3FC, 8'h5A, 4'hF);
		chk("unmapped wresp", br, 2'h2);
		chk("unmapped write", wakeRateCode, 4'hF);
		srst <= 1;
		repeat (3) @(posedge core_clk);
		srst <= 0;
		chk("reset code", wakeRateCode, `WRC_RATE_RESET);
		chk("reset counts", {wakeClockCount, sniffClockCount}, 0);
		rd_(`WRC_ADDR_POWER);
		chk("reset power", rd, `WRC_POWER_RESET);
		give_verdict();
	end
endmodule
bind wrc_wake_rate_config wrc_monitor mon (.*);
